// ===== design/evlk_pkg.sv
/*
 * Package for the code-memory programming, verify and lock block.
 * Assumes a single 40 MHz clock and an AXI4-Lite register bus.
 */
package evlk_pkg;
    localparam int          ADDR_W         = 14;
    localparam int          CODE_DEPTH     = 16384;
    localparam int          ENC_DEPTH      = 64;
    localparam int          ENC_SEL_W      = 6;
    // Oscillator periods allowed for verify data to appear or float
    localparam int          VERIFY_PERIODS = 48;
    localparam int          VERIFY_CYC     = VERIFY_PERIODS;
    localparam int          CNT_W          = 7;
    // Signature locations
    localparam logic [13:0] SIG_LOC_0      = 14'h0030;
    localparam logic [13:0] SIG_LOC_1      = 14'h0031;
    localparam logic [13:0] SIG_LOC_2      = 14'h0060;
    // Register byte offsets
    localparam logic [7:0]  REG_LOCK       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_CPU_ADDR   = 8'h08;
    localparam logic [7:0]  REG_CPU_DATA   = 8'h0c;
    localparam logic [2:0]  LOCK_RESET     = 3'h0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        EVLK_IDLE,
        EVLK_PROGRAM_STROBE_N_CODE,
        EVLK_VERIFY,
        EVLK_PROGRAM_STROBE_N_ENC,
        EVLK_PROGRAM_STROBE_N_LOCK,
        EVLK_SIGNATURE
    } evlk_mode_t;

    // Synchronised programmer pins
    typedef struct packed {
        logic [13:0] addr;
        logic [7:0]  data;
        logic        pulse_n;
        logic        rd_n;
        logic        vpp;
        logic [4:0]  ctl;
    } evlk_pins_t;
endpackage

// ===== design/evlk_top.sv
/*
 * Code-memory programming and verify port with encryption array,
 * signature bytes and three lock bits, plus an AXI4-Lite slave
 * through which the core side reads code and sees the lock state.
 * Assumes programmer pins are asynchronous and get two flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none
module evlk_top
    import evlk_pkg::*;
#(
    parameter logic [7:0] SIG_BYTE_0 = 8'ha5, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE_1 = 8'h5a, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE_2 = 8'h3c  // Arbitrary identity value
)(
    input  wire logic        REF_CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic [7:0]  PORT1_IN,
    input  wire logic [7:0]  PORT2_IN,
    input  wire logic [7:0]  PORT0_IN,
    output logic      [7:0]  PORT0_OUT,
    output logic             PORT0_OE_OUT,
    input  wire logic        PROGRAM_PULSE_N_IN,
    input  wire logic        VPP_HIGH_IN,
    input  wire logic        PSEN_N_IN,
    input  wire logic        PROGRAM_STROBE_N_RESET_IN,
    input  wire logic [2:0]  PORT3_CTL_IN,
    input  wire logic        EXTERNAL_ACCESS_SELECT_IN,
    input  wire logic        EXEC_FROM_EXTERNAL_IN,
    input  wire logic        CODE_TABLE_READ_INSTRUCTION_IN,
    output logic             EXTERNAL_ACCESS_LATCHED_OUT,
    output logic             EXTERNAL_EXEC_BLOCK_OUT,
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic      [1:0]  BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic      [31:0] RDATA,
    output logic      [1:0]  RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);
    // Arrays live outside the state struct; they are memories, not control
    logic [7:0] code_mem [CODE_DEPTH];
    logic [7:0] enc_mem  [ENC_DEPTH];

    typedef struct packed {
        evlk_pins_t  s1;
        evlk_pins_t  s2;
        logic        ea_s1;
        logic        ea_s2;
        logic        prst_s1;
        logic        prst_s2;
        logic        pulse_d;
        logic        rd_d;
        logic [13:0] addr_d;
        logic [2:0]  lock;
        logic        ea_latched;
        logic        ea_captured;
        logic [7:0]  dout;
        logic        oe;
        logic [CNT_W-1:0] cnt;
        logic [13:0] cpu_addr;
        logic [7:0]  cpu_data;
        logic        cpu_blocked;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } evlk_state_t;

    evlk_state_t st_reg;
    evlk_state_t st_next;
    evlk_mode_t  mode;
    evlk_pins_t  pin_now;
    logic [7:0]  verify_byte;
    logic [7:0]  sig_byte;
    logic        program_strobe_n_fall;
    logic        lvl1;
    logic        lvl2;
    logic        lvl3;
    logic        verify_mode;

    assign pin_now = '{addr: {PORT2_IN[5:0], PORT1_IN},
                       data: PORT0_IN, pulse_n: PROGRAM_PULSE_N_IN,
                       rd_n: PORT2_IN[7], vpp: VPP_HIGH_IN,
                       ctl: {PORT2_IN[6], PORT3_CTL_IN, PSEN_N_IN}};

    // Protection levels; undefined patterns fall to the highest level whose own and lower bits are all set
    assign lvl1 = st_reg.lock[0];
    assign lvl2 = st_reg.lock[0] & st_reg.lock[1];
    assign lvl3 = lvl2 & st_reg.lock[2];

    // Decode mode from the synchronised control pattern
    always_comb
    begin
        mode = EVLK_IDLE;
        if (st_reg.prst_s2 && !st_reg.s2.ctl[0])
        begin
            case (st_reg.s2.ctl[4:1])
                4'b0111: mode = st_reg.s2.vpp ? EVLK_PROGRAM_STROBE_N_CODE : EVLK_IDLE;
                4'b0001: mode = EVLK_VERIFY;
                4'b0110: mode = EVLK_PROGRAM_STROBE_N_ENC;
                4'b1111,
                4'b1100,
                4'b1010: mode = st_reg.s2.vpp ? EVLK_PROGRAM_STROBE_N_LOCK : EVLK_IDLE;
                4'b0000: mode = EVLK_SIGNATURE;
                default: mode = EVLK_IDLE;
            endcase
        end
    end
    assign verify_mode = (mode == EVLK_VERIFY) || (mode == EVLK_SIGNATURE);

    // Encryption byte picked by six address lines, combined by XNOR
    assign verify_byte = ~(code_mem[st_reg.s2.addr] ^
                           enc_mem[st_reg.s2.addr[ENC_SEL_W-1:0]]);

    always_comb
    begin
        case (st_reg.s2.addr)
            SIG_LOC_0: sig_byte = SIG_BYTE_0;
            SIG_LOC_1: sig_byte = SIG_BYTE_1;
            SIG_LOC_2: sig_byte = SIG_BYTE_2;
            default:   sig_byte = 8'hff;
        endcase
    end

    assign program_strobe_n_fall = st_reg.pulse_d && !st_reg.s2.pulse_n;

    // Next-state logic for pins, verify driver, lock and bus slave
    always_comb
    begin
        st_next          = st_reg;
        st_next.s1       = pin_now;
        st_next.s2       = st_reg.s1;
        st_next.ea_s1    = EXTERNAL_ACCESS_SELECT_IN;
        st_next.ea_s2    = st_reg.ea_s1;
        // Programming-mode reset is a pin too; a raw read could split the mode decode
        st_next.prst_s1  = PROGRAM_STROBE_N_RESET_IN;
        st_next.prst_s2  = st_reg.prst_s1;
        st_next.pulse_d  = st_reg.s2.pulse_n;
        st_next.rd_d     = st_reg.s2.rd_n;
        st_next.addr_d   = st_reg.s2.addr;

        // Capture the access select after reset release, then follow it until lock bit 0 is set
        if (!st_reg.ea_captured)
        begin
            st_next.ea_latched  = st_reg.ea_s2;
            st_next.ea_captured = 1'b1;
        end
        else if (!lvl1)
        begin
            st_next.ea_latched = st_reg.ea_s2;
        end

        // Verify output: one cycle from synchronised inputs, well inside 48
        if (verify_mode && !st_reg.s2.rd_n && !(mode == EVLK_VERIFY && lvl2))
        begin
            st_next.dout = (mode == EVLK_SIGNATURE) ? sig_byte : verify_byte;
            st_next.oe   = 1'b1;
        end
        else
        begin
            st_next.oe = 1'b0;
        end
        if (st_reg.cnt != '0)
        begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        if (st_reg.addr_d != st_reg.s2.addr || st_reg.rd_d != st_reg.s2.rd_n)
        begin
            st_next.cnt = CNT_W'(VERIFY_CYC);         // Timing window tracker
        end

        // Lock bits program on the pulse's falling edge
        if (program_strobe_n_fall && mode == EVLK_PROGRAM_STROBE_N_LOCK)
        begin
            case (st_reg.s2.ctl[4:1])
                4'b1111: st_next.lock[0] = 1'b1;
                4'b1100: st_next.lock[1] = 1'b1;
                default: st_next.lock[2] = 1'b1;
            endcase
        end

        // AXI4-Lite write: address and data in either order
        if (AWVALID && !st_reg.aw_got)
        begin
            st_next.aw_got  = 1'b1;
            st_next.aw_addr = AWADDR[7:0];
        end
        if (WVALID && !st_reg.w_got)
        begin
            st_next.w_got  = 1'b1;
            st_next.w_data = WDATA;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
        begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = RESP_OKAY;
            if (st_reg.aw_addr == REG_CPU_ADDR)
            begin
                st_next.cpu_addr = st_reg.w_data[13:0];
            end
            else if (st_reg.aw_addr != REG_LOCK && st_reg.aw_addr != REG_STATUS
                     && st_reg.aw_addr != REG_CPU_DATA)
            begin
                st_next.bresp = RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && BREADY)
        begin
            st_next.bvalid = 1'b0;
        end

        // CPU code-table fetch: blocked when executing externally under lock
        st_next.cpu_blocked = lvl1 && EXEC_FROM_EXTERNAL_IN
                              && CODE_TABLE_READ_INSTRUCTION_IN;
        st_next.cpu_data    = st_next.cpu_blocked ? 8'hff : code_mem[st_reg.cpu_addr];

        // AXI4-Lite read
        if (ARVALID && !st_reg.rvalid)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            case (ARADDR[7:0])
                REG_LOCK:     st_next.rdata = {29'h0, st_reg.lock};
                REG_STATUS:   st_next.rdata = {27'h0, st_reg.cpu_blocked, lvl3,
                                               st_reg.ea_latched, st_reg.oe,
                                               st_reg.cnt != '0};
                REG_CPU_ADDR: st_next.rdata = {18'h0, st_reg.cpu_addr};
                REG_CPU_DATA: st_next.rdata = {24'h0, st_reg.cpu_data};
                default:
                begin
                    st_next.rdata = 32'h0;
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (st_reg.rvalid && RREADY)
        begin
            st_next.rvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            st_reg       <= '0;
            st_reg.s1    <= '{addr: 14'h0, data: 8'h0, pulse_n: 1'b1, rd_n: 1'b1,
                              vpp: 1'b0, ctl: 5'h1f};
            st_reg.s2    <= '{addr: 14'h0, data: 8'h0, pulse_n: 1'b1, rd_n: 1'b1,
                              vpp: 1'b0, ctl: 5'h1f};
            st_reg.pulse_d <= 1'b1;
            st_reg.rd_d  <= 1'b1;
            st_reg.lock  <= LOCK_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Memory writes; erased state is all ones. Code writes refused under lock.
    initial
    begin
        for (int i = 0; i < ENC_DEPTH; i++)
        begin
            enc_mem[i] = 8'hff;
        end
        for (int i = 0; i < CODE_DEPTH; i++)
        begin
            code_mem[i] = 8'hff;
        end
    end
    // Plain always: the erase loop above also writes these arrays, and a
    // single-writer clocked process would forbid that second writer
    always @(posedge REF_CLK_IN)
    begin
        if (program_strobe_n_fall && mode == EVLK_PROGRAM_STROBE_N_CODE && !lvl1)
        begin
            code_mem[st_reg.s2.addr] <= code_mem[st_reg.s2.addr] & st_reg.s2.data;
        end
        if (program_strobe_n_fall && mode == EVLK_PROGRAM_STROBE_N_ENC)
        begin
            enc_mem[st_reg.s2.addr[ENC_SEL_W-1:0]] <=
                enc_mem[st_reg.s2.addr[ENC_SEL_W-1:0]] & st_reg.s2.data;
        end
    end

    assign PORT0_OUT    = st_reg.dout;
    assign PORT0_OE_OUT = st_reg.oe;
    assign EXTERNAL_ACCESS_LATCHED_OUT = st_reg.ea_latched;
    assign EXTERNAL_EXEC_BLOCK_OUT     = lvl3;
    assign AWREADY = !st_reg.aw_got;
    assign WREADY  = !st_reg.w_got;
    assign BVALID  = st_reg.bvalid;
    assign BRESP   = st_reg.bresp;
    assign ARREADY = !st_reg.rvalid;
    assign RVALID  = st_reg.rvalid;
    assign RDATA   = st_reg.rdata;
    assign RRESP   = st_reg.rresp;
endmodule
`default_nettype wire

// ===== tb/evlk_chk.sv
/* Pin checker for evlk_top: verify timing, lock effects, access latch.
   Assumes PSEN held low and the reset pin held in programming mode. */
`timescale 1ns/1ps
`default_nettype none
module evlk_chk (
    input  wire logic       REF_CLK_IN,
    input  wire logic       NRST_IN,
    input  wire logic [7:0] PORT1_IN,
    input  wire logic [7:0] PORT2_IN,
    input  wire logic [7:0] PORT0_OUT,
    input  wire logic       PORT0_OE_OUT,
    input  wire logic       PROGRAM_PULSE_N_IN,
    input  wire logic       VPP_HIGH_IN,
    input  wire logic [2:0] PORT3_CTL_IN,
    input  wire logic       EXTERNAL_ACCESS_LATCHED_OUT,
    input  wire logic       EXTERNAL_EXEC_BLOCK_OUT
);
    localparam int VW = 48;
    logic [3:0] mode;
    logic [2:0] lk_reg;
    logic       lk_all;
    logic       vmode;
    // Mode pattern and lock summary
    assign mode   = {PORT2_IN[6], PORT3_CTL_IN};
    assign vmode  = mode == 4'h1;
    assign lk_all = &lk_reg;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // Shadow lock bits; they lead the design by its pin synchroniser
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN)
        if (!NRST_IN)
            lk_reg <= 3'h0;
        else if (!PROGRAM_PULSE_N_IN && VPP_HIGH_IN)
            lk_reg <= lk_reg | {mode == 4'ha, mode == 4'hc, mode == 4'hf};
    a_idle_float: assert property (PORT2_IN[7] [*4] |-> !PORT0_OE_OUT)
        else $error("data driven with strobe high");
    a_float_bound: assert property ($rose(PORT2_IN[7]) |-> ##[1:VW] !PORT0_OE_OUT)
        else $error("data not released in time");
    a_verify_drive: assert property ((vmode && !PORT2_IN[7] && !lk_reg[1]) [*8]
        |-> PORT0_OE_OUT)
        else $error("verify data not driven");
    a_locked_float: assert property (lk_reg[1] && $past(lk_reg[1], 4) && vmode
        |-> !PORT0_OE_OUT)
        else $error("verify driven while locked");
    a_data_hold: assert property ((vmode && !PORT2_IN[7] && $stable(PORT1_IN)
        && $stable(PORT2_IN)) [*5] |-> $stable(PORT0_OUT))
        else $error("verify data moved with address stable");
    a_exec_cause: assert property (EXTERNAL_EXEC_BLOCK_OUT |-> lk_all)
        else $error("external execution blocked early");
    a_exec_block: assert property (lk_all && $past(lk_all, 4) |-> EXTERNAL_EXEC_BLOCK_OUT)
        else $error("external execution not blocked");
    a_ea_frozen: assert property (lk_reg[0] && $past(lk_reg[0], 4)
        |-> $stable(EXTERNAL_ACCESS_LATCHED_OUT))
        else $error("access select not frozen");
endmodule
bind evlk_top evlk_chk u_chk (.*);
`default_nettype wire

// ===== tb/evlk_program_strobe_n_model.sv
/* Programmer model: drives address, data, mode, strobe and pulses.
   Assumes pull-ups on the data lines; the bench merges the wire. */
`timescale 1ns/1ps
`default_nettype none
module evlk_program_strobe_n_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] dat_in,
    input  wire logic       oe_in,
    output logic      [7:0] p1_out,
    output logic      [7:0] p2_out,
    output logic      [7:0] p0_out,
    output logic      [2:0] ctl_out,
    output logic            pulse_n_out,
    output logic            vpp_out
);
    localparam int HOLD = 48;
    localparam int GAP  = 400; // 10 us high at 40 MHz; slow, but legal
    // Idle levels at time zero
    initial
    begin
        {p1_out, p2_out, p0_out, ctl_out} = {8'h00, 8'h80, 8'hff, 3'h7};
        pulse_n_out = 1'b1;
        vpp_out = 1'b0;
    end
    // Pins change just after an edge
    task automatic setup(input logic [3:0] m, input logic [13:0] a, input logic [7:0] d,
                         input logic rd_n);
        @(posedge clk_in);
        p1_out <= a[7:0];
        p2_out <= {rd_n, m[3], a[13:8]};
        ctl_out <= m[2:0];
        p0_out <= d;
    endtask
    // Address and data stand HOLD periods around every pulse
    task automatic program_strobe_n_byte(input logic [3:0] m, input logic [13:0] a, input logic [7:0] d,
                             input int n);
        setup(m, a, d, m != 4'ha);
        vpp_out <= 1'b1;
        repeat (HOLD) @(posedge clk_in);
        repeat (n)
        begin
            pulse_n_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            pulse_n_out <= 1'b1;
            repeat (GAP) @(posedge clk_in);
        end
        vpp_out <= 1'b0;
        p0_out <= 8'hff;
    endtask
    // Strobe low with the address; sample at the bound, then release
    task automatic verify(input logic [3:0] m, input logic [13:0] a, output logic [7:0] d,
                          output logic oe);
        setup(m, a, 8'hff, 1'b0);
        repeat (HOLD) @(posedge clk_in);
        d = dat_in;
        oe = oe_in;
        p2_out[7] <= 1'b1;
        repeat (HOLD) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ===== tb/evlk_top_tb.sv
/* Bench for evlk_top: program, verify, signature, registers, locks.
   Expectations come from an array model of code and encryption bytes. */
`timescale 1ns/1ps
`default_nettype none
module evlk_top_tb
    import evlk_pkg::*;
;
    localparam logic [7:0] SV [3] = '{8'h1e, 8'h2d, 8'h4b}; // Arbitrary identity values
    logic [13:0] ad [3] = '{14'h0005, 14'h2345, 14'h0033};
    logic [13:0] sl [3] = '{SIG_LOC_0, SIG_LOC_1, SIG_LOC_2};
    logic REF_CLK_IN, NRST_IN, PROGRAM_PULSE_N_IN, VPP_HIGH_IN, PORT0_OE_OUT;
    logic PSEN_N_IN = 1'b0;
    logic PROGRAM_STROBE_N_RESET_IN = 1'b1;
    logic [3:0] WSTRB = 4'hf;
    logic EXTERNAL_ACCESS_SELECT_IN, EXEC_FROM_EXTERNAL_IN, CODE_TABLE_READ_INSTRUCTION_IN;
    logic EXTERNAL_ACCESS_LATCHED_OUT, EXTERNAL_EXEC_BLOCK_OUT;
    logic [7:0] PORT1_IN, PORT2_IN, PORT0_IN, PORT0_OUT, p0, d, ek;
    logic [2:0] PORT3_CTL_IN;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rd, seed;
    logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    logic [1:0] BRESP, RRESP, r;
    logic [7:0] code [int];
    logic [7:0] enc [64] = '{default: 8'hff};
    int bad_count, checks, i;
    // Data lines: design when enabled, else programmer or pull-ups
    assign PORT0_IN = PORT0_OE_OUT ? PORT0_OUT : p0;
    evlk_top #(.SIG_BYTE_0(SV[0]), .SIG_BYTE_1(SV[1]), .SIG_BYTE_2(SV[2])) u_dut (.*);
    evlk_program_strobe_n_model u_program_strobe_n (.clk_in(REF_CLK_IN), .dat_in(PORT0_IN), .oe_in(PORT0_OE_OUT),
        .p1_out(PORT1_IN), .p2_out(PORT2_IN), .p0_out(p0), .ctl_out(PORT3_CTL_IN),
        .pulse_n_out(PROGRAM_PULSE_N_IN), .vpp_out(VPP_HIGH_IN));
    initial
    begin
        REF_CLK_IN = 1'b0;
        forever #12.5 REF_CLK_IN = ~REF_CLK_IN;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // A spent wait bound counts as a mismatch and ends the run
    task automatic tmo(input int n);
        if (n >= 64)
        begin
            bad_count++;
            summarize();
        end
    endtask
    // Write: address and data offered together, each released when taken
    task automatic axw(input logic [31:0] a, input logic [31:0] v);
        int n;
        {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, v, 3'h7};
        for (n = 0; n < 64 && !(BVALID && BREADY); n++)
        begin
            @(posedge REF_CLK_IN);
            if (AWREADY)
                AWVALID <= 1'b0;
            if (WREADY)
                WVALID <= 1'b0;
        end
        BREADY <= 1'b0;
        r = BRESP;
        tmo(n);
    endtask
    task automatic axr(input logic [31:0] a);
        int n;
        {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
        for (n = 0; n < 64 && !RVALID; n++)
        begin
            @(posedge REF_CLK_IN);
            if (ARREADY)
                ARVALID <= 1'b0;
        end
        RREADY <= 1'b0;
        {rd, r} = {RDATA, RRESP};
        tmo(n);
    endtask
    // Verify through the programmer; data compared only when expected to be driven
    task automatic vchk(input logic [3:0] m, input logic [13:0] a, input logic [8:0] e);
        logic o;
        u_program_strobe_n.verify(m, a, d, o);
        chk("verify_oe", o, e[8]);
        if (e[8])
            chk("verify_data", d, e[7:0]);
    endtask
    function automatic logic [8:0] ex(input logic [13:0] a);
        return {1'b1, ~(code[a] ^ enc[a[5:0]])};
    endfunction
    initial
    begin
        {NRST_IN, EXTERNAL_ACCESS_SELECT_IN, EXEC_FROM_EXTERNAL_IN} = 3'h0;
        {CODE_TABLE_READ_INSTRUCTION_IN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h0;
        {AWADDR, WDATA, ARADDR, seed} = {96'h0, 32'h2e};
        repeat (16) @(posedge REF_CLK_IN);
        NRST_IN <= 1'b1;
        for (i = 0; i < 3; i++)
            vchk(4'h0, sl[i], {1'b1, SV[i]});
        for (i = 0; i < 3; i++)
        begin
            code[ad[i]] = xs() & 32'hff;
            u_program_strobe_n.program_strobe_n_byte(4'h7, ad[i], code[ad[i]], 5);
            vchk(4'h1, ad[i], ex(ad[i]));
        end
        ek = xs() & 32'hff;
        enc[5] = ek;
        u_program_strobe_n.program_strobe_n_byte(4'h6, 14'h0005, ek, 25);
        for (i = 0; i < 3; i++)
            vchk(4'h1, ad[i], ex(ad[i]));
        axw({24'h0, REG_CPU_ADDR}, 32'h5);
        chk("bresp_ok", r, RESP_OKAY);
        axr({24'h0, REG_CPU_DATA});
        chk("code_read", rd, code[5]);
        chk("rresp_ok", r, RESP_OKAY);
        axw(32'h40, 32'h0);
        chk("bresp_unmapped", r, RESP_SLVERR);
        axr(32'h40);
        chk("rresp_unmapped", r, RESP_SLVERR);
        EXTERNAL_ACCESS_SELECT_IN <= 1'b1;
        u_program_strobe_n.program_strobe_n_byte(4'hf, 14'h0, 8'hff, 25);
        EXTERNAL_ACCESS_SELECT_IN <= 1'b0;
        // Erased location and an all-zero byte: any accepted pulse would show
        code[14'h0100] = 8'hff;
        u_program_strobe_n.program_strobe_n_byte(4'h7, 14'h0100, 8'h00, 5);
        vchk(4'h1, 14'h0100, ex(14'h0100));
        chk("ea_latched", EXTERNAL_ACCESS_LATCHED_OUT, 1'b1);
        {EXEC_FROM_EXTERNAL_IN, CODE_TABLE_READ_INSTRUCTION_IN} <= 2'h3;
        // The fetched byte is registered; let it follow the new core levels
        repeat (2) @(posedge REF_CLK_IN);
        axr({24'h0, REG_CPU_DATA});
        chk("table_read", rd, 32'hff);
        u_program_strobe_n.program_strobe_n_byte(4'hc, 14'h0, 8'hff, 25);
        vchk(4'h1, 14'h0005, 9'h0);
        chk("exec_block", EXTERNAL_EXEC_BLOCK_OUT, 1'b0);
        u_program_strobe_n.program_strobe_n_byte(4'ha, 14'h0, 8'hff, 25);
        chk("exec_block", EXTERNAL_EXEC_BLOCK_OUT, 1'b1);
        axr({24'h0, REG_LOCK});
        chk("lock_bits", rd, 32'h7);
        summarize();
    end
endmodule
`default_nettype wire
